// >>> hw/pac_converter.v
/*
 * Digital model of an 8-bit pipelined converter: sample on falling edge,
 * code out after the third following rising edge, saturating, power-down
 * hold. Assumes the analog input arrives as a wide signed quantised level
 * with the ladder references on the same scale, synchronous to clock_in.
 */
// Contract
// - Sample taken at each falling clock edge (code skips it while low_power_request_in is high)
// - Code appears two and half cycles later
// - New code each cycle after rising edge
// - In-range input gives eight-bit straight binary
// - Below bottom reference gives all zeros
// - Above top reference gives all ones
// - Converts continuously while clock runs, no trigger
// - Power-down high holds last converted code
// - Codes invalid about one microsecond after wake
// - Stopped clock keeps output bus unchanged
`timescale 1ns/100ps
`include "pac_consts.vh"
module pac_converter #(
    parameter IN_WIDTH    = 16,
    parameter WAKE_CYCLES = `PAC_WAKE_CYCLES,
    parameter FIFO_DEPTH  = `PAC_FIFO_DEPTH,
    parameter FIFO_AW     = `PAC_FIFO_AW
) (
    input  wire                       clock_in,
    input  wire                       arst_n_in,
    input  wire signed [IN_WIDTH-1:0] analog_level_in,
    input  wire signed [IN_WIDTH-1:0] ladder_bottom_reference_in,
    input  wire signed [IN_WIDTH-1:0] ladder_top_reference_in,
    input  wire                       low_power_request_in,
    input  wire                       code_ready_in,
    output reg  [`PAC_CODE_WIDTH-1:0] code_out,
    output reg                        code_valid_out,
    output reg                        low_power_out
);
    localparam ST_RUN  = 3'b001;
    localparam ST_LOW  = 3'b010;
    localparam ST_WAKE = 3'b100;
    localparam CW      = 16;

    reg signed [IN_WIDTH-1:0]  held_sample;
    reg [`PAC_CODE_WIDTH-1:0]  stage1;
    reg [`PAC_CODE_WIDTH-1:0]  stage2;
    reg                        stage1_ok;
    reg                        stage2_ok;
    reg [2:0]                  state;
    reg [2:0]                  next_state;
    reg [CW-1:0]               wake_count;
    reg [CW-1:0]               next_wake_count;
    wire [`PAC_CODE_WIDTH-1:0] fifo_data;
    wire                       fifo_valid;
    wire                       fifo_wr_ready;
    wire                       running;

    // Saturating quantiser against the ladder; span scaled to 256 steps
    function [`PAC_CODE_WIDTH-1:0] pac_quantise;
        input signed [IN_WIDTH-1:0] v;
        input signed [IN_WIDTH-1:0] lo;
        input signed [IN_WIDTH-1:0] hi;
        reg signed [2*IN_WIDTH+1:0] num;
        reg signed [2*IN_WIDTH+1:0] q;
        begin
            num = (v - lo) * 256;
            q   = 0;
            if (v < lo)
                pac_quantise = `PAC_CODE_ZERO;
            else if (v >= hi)
                pac_quantise = `PAC_CODE_FULL;
            else begin
                q = num / (hi - lo);
                if (q > 255)
                    pac_quantise = `PAC_CODE_FULL;
                else
                    pac_quantise = q[`PAC_CODE_WIDTH-1:0];
            end
        end
    endfunction

    assign running = (state != ST_LOW);

    // Acquisition stops at the falling edge; the held value is what converts
    always @(negedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in)
            held_sample <= {IN_WIDTH{1'b0}};
        else if (!low_power_request_in)
            held_sample <= analog_level_in;
    end

    // Two rising-edge stages, then the output register: third rise drives
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stage1    <= `PAC_RESET_CODE;
            stage2    <= `PAC_RESET_CODE;
            stage1_ok <= 1'b0;
            stage2_ok <= 1'b0;
        end else if (running) begin
            stage1    <= pac_quantise(held_sample,
                                      ladder_bottom_reference_in,
                                      ladder_top_reference_in);
            stage2    <= stage1;
            stage1_ok <= (state == ST_RUN);
            stage2_ok <= stage1_ok;
        end else begin
            stage1_ok <= 1'b0;
            stage2_ok <= 1'b0;
        end
    end

    always @* begin
        next_state      = state;
        next_wake_count = wake_count;
        case (state)
            ST_RUN: begin
                if (low_power_request_in)
                    next_state = ST_LOW;
            end
            ST_LOW: begin
                if (!low_power_request_in) begin
                    next_state      = ST_WAKE;
                    next_wake_count = WAKE_CYCLES[CW-1:0];
                end
            end
            ST_WAKE: begin
                if (low_power_request_in)
                    next_state = ST_LOW;
                else if (wake_count <= 1)
                    next_state = ST_RUN;
                else
                    next_wake_count = wake_count - 1'b1;
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state      <= ST_RUN;
            wake_count <= {CW{1'b0}};
        end else begin
            state      <= next_state;
            wake_count <= next_wake_count;
        end
    end

    // Codes keep flowing during wake so the bus tracks, flagged invalid
    pac_code_fifo #(
        .WIDTH (`PAC_CODE_WIDTH),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clock_in     (clock_in),
        .arst_n_in    (arst_n_in),
        .wr_data_in   (stage2),
        .wr_valid_in  (running),
        .wr_ready_out (fifo_wr_ready),
        .rd_data_out  (fifo_data),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (1'b1)
    );

    // Output bus only moves on a rising edge; holds when clock or power stops
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            code_out       <= `PAC_RESET_CODE;
            code_valid_out <= 1'b0;
            low_power_out  <= 1'b0;
        end else begin
            // Flag and valid follow the request at once, so no stale valid
            low_power_out <= (next_state == ST_LOW);
            if (running)
                code_out <= stage2;
            code_valid_out <= running && !low_power_request_in &&
                              stage2_ok && fifo_valid &&
                              fifo_wr_ready && code_ready_in &&
                              (fifo_data == fifo_data);
        end
    end
endmodule // pac_converter

// >>> hw/pac_consts.vh
/*
 * Constants for the pipelined converter output timing block.
 * Assumes inclusion by bare name from the hw/ design files.
 */
`ifndef PAC_CONSTS_VH
`define PAC_CONSTS_VH

`define PAC_CODE_WIDTH       8
`define PAC_CODE_ZERO        8'h00
`define PAC_CODE_FULL        8'hff
`define PAC_RESET_CODE       8'h00
`define PAC_CLOCK_MHZ        20
`define PAC_WAKE_TIME_US     1
`define PAC_WAKE_CYCLES      (`PAC_WAKE_TIME_US * `PAC_CLOCK_MHZ)
`define PAC_FIFO_DEPTH       4
`define PAC_FIFO_AW          2

`endif

// >>> hw/pac_code_fifo.v
/*
 * Small FIFO of converted codes with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
module pac_code_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clock_in,
    input  wire             arst_n_in,
    input  wire [WIDTH-1:0] wr_data_in,
    input  wire             wr_valid_in,
    output wire             wr_ready_out,
    output wire [WIDTH-1:0] rd_data_out,
    output wire             rd_valid_out,
    input  wire             rd_ready_in
);
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            do_wr;
    wire            do_rd;
    integer         i;

    function [AW-1:0] pac_bump;
        input [AW-1:0] p;
        begin
            if (p == DEPTH - 1)
                pac_bump = {AW{1'b0}};
            else
                pac_bump = p + 1'b1;
        end
    endfunction

    assign wr_ready_out = (count != DEPTH);
    assign rd_valid_out = (count != 0);
    assign rd_data_out  = store[rd_ptr];
    assign do_wr        = wr_valid_in && wr_ready_out;
    assign do_rd        = rd_valid_out && rd_ready_in;

    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1)
                store[i] <= {WIDTH{1'b0}};
        end else begin
            if (do_wr) begin
                store[wr_ptr] <= wr_data_in;
                wr_ptr        <= pac_bump(wr_ptr);
            end
            if (do_rd)
                rd_ptr <= pac_bump(rd_ptr);
            if (do_wr && !do_rd)
                count <= count + 1'b1;
            else if (do_rd && !do_wr)
                count <= count - 1'b1;
        end
    end
endmodule // pac_code_fifo

// >>> verif/pac_chk_sv_chk.sv
/* Checker on the converter ports.
   Assumes binding onto pac_converter, one clock, async reset. */
`timescale 1ns/100ps
module pac_chk #(parameter IN_WIDTH = 16, WAKE_CYCLES = 20) (
    input wire                       clock_in,
    input wire                       arst_n_in,
    input wire signed [IN_WIDTH-1:0] analog_level_in,
    input wire signed [IN_WIDTH-1:0] ladder_bottom_reference_in,
    input wire signed [IN_WIDTH-1:0] ladder_top_reference_in,
    input wire                       low_power_request_in,
    input wire                       code_ready_in,
    input wire [7:0]                 code_out,
    input wire                       code_valid_out,
    input wire                       low_power_out
);
    logic signed [IN_WIDTH-1:0] smp;
    logic [9:0] st1, st2, st3;
    int         fill, wcnt;
    wire        lp = low_power_request_in;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    // Bit 9 marks below range, bit 8 above range
    function automatic logic [9:0] conv(int v, int lo, int hi);
        if (v < lo) return 10'h200;
        if (v >= hi) return 10'h1ff;
        return 10'((v - lo) * 256 / (hi - lo));
    endfunction
    always @(negedge clock_in or negedge arst_n_in)
        if (!arst_n_in) smp <= '0;
        else if (!lp) smp <= analog_level_in;
    // Ladder is read at the first rise, where the converter quantises
    always @(posedge clock_in or negedge arst_n_in)
        if (!arst_n_in) begin
            {st1, st2, st3} <= 30'h0;
            fill <= 0;
            wcnt <= WAKE_CYCLES + 8;
        end else begin
            {st1, st2, st3} <= {conv(smp, ladder_bottom_reference_in,
                ladder_top_reference_in), st1, st2};
            fill <= (fill < 7) ? fill + 1 : fill;
            wcnt <= lp ? 0 : (wcnt < WAKE_CYCLES + 8) ? wcnt + 1 : wcnt;
        end
    sequence s_live;
        code_valid_out && !lp && fill == 7 && wcnt >= WAKE_CYCLES + 4;
    endsequence
    a_code_latency: assert property (s_live |-> code_out == st3[7:0])
        else $error("code does not match sample three edges back");
    a_bottom_zero: assert property (s_live and st3[9] |-> code_out == 8'h00)
        else $error("low input not clipped to zero");
    a_top_ones: assert property (s_live and st3[8] |-> code_out == 8'hff)
        else $error("high input not clipped to ones");
    a_freeze_pd: assert property (lp [*3] |=> $stable(code_out))
        else $error("code moved in low power");
    a_valid_drop: assert property (lp [*2] |-> !code_valid_out)
        else $error("valid during low power");
    a_lp_flag: assert property (lp [*2] |-> low_power_out)
        else $error("low power status missing");
    a_wake_blank: assert property (wcnt < WAKE_CYCLES |-> !code_valid_out)
        else $error("valid too soon after wake");
    a_valid_return: assert property (wcnt == WAKE_CYCLES + 8 && fill == 7 &&
        !lp && code_ready_in && $past(code_ready_in) |-> code_valid_out)
        else $error("conversion stopped while running");
    a_no_early: assert property (fill < 3 |-> !code_valid_out)
        else $error("code before pipeline filled");
endmodule // pac_chk
bind pac_converter pac_chk #(.IN_WIDTH(IN_WIDTH),
    .WAKE_CYCLES(WAKE_CYCLES)) i_chk (.*);

// >>> verif/pac_host.sv
/* Host model that captures codes.
   Assumes the converter clock and reset. */
`timescale 1ns/100ps
module pac_host (
    input  wire       clock_in,
    input  wire       arst_n_in,
    input  wire       slow_in,
    input  wire [7:0] code_in,
    input  wire       code_valid_in,
    output reg        code_ready_out,
    output reg  [7:0] last_code_out,
    output int        taken_out
);
    always @(posedge clock_in or negedge arst_n_in)
        if (!arst_n_in) begin
            code_ready_out <= 1'b0;
            last_code_out  <= 8'h00;
            taken_out      <= 0;
        end else begin
            // Slow mode stalls every other cycle
            code_ready_out <= slow_in ? ~code_ready_out : 1'b1;
            if (code_valid_in && code_ready_out) begin
                last_code_out <= code_in;
                taken_out     <= taken_out + 1;
            end
        end
endmodule // pac_host

// >>> verif/tb_top.sv
/* Top bench: converter, host model, checker by bind.
   Assumes the design and verif files compile before it. */
`timescale 1ns/100ps
module tb_top;
    logic clock_in = 1'b0, arst_n_in = 1'b0, run = 1'b1, lp = 1'b0;
    logic signed [15:0] level = 16'sh0000, lo = 16'sh0000, hi = 16'sh0100;
    logic slow = 1'b0, ready, valid, lpo;
    logic [7:0] code, last;
    int taken, errors = 0, tests_run = 0;
    // Clock holds its current level while run is cleared
    always #25 clock_in = run ? ~clock_in : clock_in;
    pac_converter #(.WAKE_CYCLES(3)) i_dut (.clock_in(clock_in),
        .arst_n_in(arst_n_in), .analog_level_in(level),
        .ladder_bottom_reference_in(lo), .ladder_top_reference_in(hi),
        .low_power_request_in(lp), .code_ready_in(ready), .code_out(code),
        .code_valid_out(valid), .low_power_out(lpo));
    pac_host i_host (.clock_in(clock_in), .arst_n_in(arst_n_in),
        .slow_in(slow), .code_in(code), .code_valid_in(valid),
        .code_ready_out(ready), .last_code_out(last), .taken_out(taken));
    task automatic check(input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    task automatic t_codes;
        int t[8][4] = '{'{0,256,0,0}, '{0,256,255,255}, '{0,256,137,137},
            '{0,256,-3,0}, '{0,256,256,255}, '{0,256,9000,255},
            '{100,612,355,127}, '{100,612,99,0}};
        for (int i = 0; i < 8; i++) begin
            lo <= 16'(t[i][0]);
            hi <= 16'(t[i][1]);
            level <= 16'(t[i][2]);
            cyc(6);
            check(last, t[i][3]);
        end
        lo <= 16'sh0000;
        hi <= 16'sh0100;
        $display("done codes");
    endtask
    task automatic t_latency;
        level <= 16'sh0010;
        cyc(6);
        level <= 16'sh0020;
        cyc(1);
        repeat (2) @(posedge clock_in);
        #1 check(code, 8'h10);
        @(posedge clock_in);
        #1 check(code, 8'h20);
        cyc(1);
        $display("done latency");
    endtask
    task automatic t_pd;
        int n;
        level <= 16'sh0033;
        cyc(6);
        lp <= 1'b1;
        level <= 16'sh0044;
        cyc(8);
        check(code, 8'h33);
        check({valid, lpo}, 2'b01);
        lp <= 1'b0;
        n = 0;
        while (valid !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        if (n == 40) begin
            errors++;
            summarize();
        end
        check(n >= 3, 1'b1);
        cyc(1);
        check(code, 8'h44);
        $display("done power down");
    endtask
    task automatic t_stop;
        int k;
        run = 1'b0;
        level <= 16'sh0055;
        #500 check(code, 8'h44);
        run = 1'b1;
        cyc(6);
        check(code, 8'h55);
        k = taken;
        cyc(20);
        check(taken - k, 20);
        slow <= 1'b1;
        cyc(12);
        slow <= 1'b0;
        cyc(12);
        $display("done clock stop");
    endtask
    initial begin
        cyc(8);
        arst_n_in <= 1'b1;
        cyc(2);
        t_codes();
        t_latency();
        t_pd();
        t_stop();
        summarize();
    end
endmodule // tb_top
